// ==== design/bridge_parity_consts.vh ====
// Constants of the bridge parity and error handling block.
`ifndef BRIDGE_PARITY_CONSTS_VH
`define BRIDGE_PARITY_CONSTS_VH

// ****************************************************************
// Register byte addresses.
// ****************************************************************
`define REG_PRI_COMMAND 8'h00
`define REG_PRI_STATUS 8'h04
`define REG_SEC_STATUS 8'h08
`define REG_BRIDGE_CTRL 8'h0C
`define REG_CFG_DATA 8'h10

// ****************************************************************
// Field positions.
// ****************************************************************
`define CMD_PERR_RESP 6
`define CMD_SERR_EN 8
`define BCTL_PERR_RESP 0
`define STAT_DATA_PERR 8
`define STAT_SIG_SERR 14
`define STAT_DET_PERR 15

// ****************************************************************
// Reset values and timing.
// ****************************************************************
`define PRI_COMMAND_RST 16'h0000
`define BRIDGE_CTRL_RST 16'h0000
`define STATUS_RST 16'h0000
`define CFG_DATA_RST 32'h00000000
`define PERR_LAG 2

`endif

// ==== design/parity_check.v ====
// Even parity checker over address/data, command/byte enables and par.
`timescale 1ns/1ns

module parity_check #(
    parameter DATA_W = 32,
    parameter CMD_W = 4
) (
    // Bus lines of one phase.
    input wire [DATA_W-1:0] ad,
    input wire [CMD_W-1:0] cbe,
    input wire par,
    // Result.
    output wire bad
);

    // The set of all lines plus par must hold an even count of ones.
    assign bad = ^{ad, cbe, par};

endmodule // parity_check

// ==== design/bridge_parity_error_handling.v ====
// Parity checking, forwarding and error reporting of a two-port bridge.
`timescale 1ns/1ns
`include "bridge_parity_consts.vh"

module bridge_parity_error_handling #(
    parameter DATA_W = 32,
    parameter CMD_W = 4
) (
    // Clock and reset.
    input wire clk_sys,
    input wire rst,
    // Register port.
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [31:0] reg_rdata,
    // Primary bus phases from the primary front end.
    input wire primary_addr_valid,
    input wire primary_data_valid,
    input wire [DATA_W-1:0] primary_ad,
    input wire [CMD_W-1:0] primary_cbe,
    input wire primary_par,
    input wire primary_hit,
    input wire primary_cfg_write,
    input wire primary_read_return,
    input wire primary_end,
    // Secondary bus phases from the secondary front end.
    input wire secondary_addr_valid,
    input wire secondary_data_valid,
    input wire [DATA_W-1:0] secondary_ad,
    input wire [CMD_W-1:0] secondary_cbe,
    input wire secondary_par,
    input wire secondary_hit,
    input wire secondary_read_return,
    input wire secondary_end,
    // Primary bus responses.
    output reg primary_devsel_n,
    output reg primary_target_ready_n,
    output wire primary_parity_error_n,
    output reg primary_system_error_n,
    // Secondary bus responses.
    output reg secondary_devsel_n,
    output wire secondary_parity_error_n,
    // Data forwarded from primary to secondary.
    output reg secondary_fwd_valid,
    output reg [DATA_W-1:0] secondary_fwd_ad,
    output reg [CMD_W-1:0] secondary_fwd_cbe,
    output reg secondary_fwd_par,
    // Data forwarded from secondary to primary.
    output reg primary_fwd_valid,
    output reg [DATA_W-1:0] primary_fwd_ad,
    output reg [CMD_W-1:0] primary_fwd_cbe,
    output reg primary_fwd_par
);

    // ************************************************************
    // Declarations.
    // ************************************************************
    reg [15:0] pri_command;
    reg [15:0] bridge_ctrl;
    reg [15:0] pri_status;
    reg [15:0] sec_status;
    reg [31:0] cfg_data;
    reg [31:0] next_rdata;
    reg [15:0] pri_status_set;
    reg [15:0] sec_status_set;
    reg [`PERR_LAG-1:0] pri_perr_pipe_n;
    reg [`PERR_LAG-1:0] sec_perr_pipe_n;
    wire pri_bad;
    wire sec_bad;
    wire pri_resp;
    wire sec_resp;
    wire serr_en;
    wire pri_addr_err;
    wire sec_addr_err;
    wire pri_cfg_err;
    wire pri_read_err;
    wire sec_read_err;
    wire serr_event;
    wire pri_perr_event;
    wire sec_perr_event;
    wire pri_fwd_take;
    wire [15:0] status_clear;

    // ************************************************************
    // Parity checkers, one per bus.
    // ************************************************************

    // The same checker serves the address and the data phases.
    parity_check #(
        .DATA_W(DATA_W),
        .CMD_W(CMD_W)
    ) u_pri_check (
        .ad(primary_ad),
        .cbe(primary_cbe),
        .par(primary_par),
        .bad(pri_bad)
    );

    parity_check #(
        .DATA_W(DATA_W),
        .CMD_W(CMD_W)
    ) u_sec_check (
        .ad(secondary_ad),
        .cbe(secondary_cbe),
        .par(secondary_par),
        .bad(sec_bad)
    );

    // ************************************************************
    // Control bits and error events.
    // ************************************************************

    // Enables taken from the command and bridge control registers.
    assign pri_resp = pri_command[`CMD_PERR_RESP];
    assign serr_en = pri_command[`CMD_SERR_EN];
    assign sec_resp = bridge_ctrl[`BCTL_PERR_RESP];

    // Address parity is checked on every address phase of each bus.
    assign pri_addr_err = primary_addr_valid & pri_bad;
    assign sec_addr_err = secondary_addr_valid & sec_bad;

    // Data phase errors split by the kind of transfer.
    assign pri_cfg_err = primary_data_valid & primary_cfg_write & pri_bad;
    assign pri_read_err = primary_data_valid & primary_read_return &
                          pri_bad;
    assign sec_read_err = secondary_data_valid & secondary_read_return &
                          sec_bad;

    // System error needs the enable and the response bit of the bus.
    assign serr_event = (pri_addr_err & serr_en & pri_resp) |
                        (sec_addr_err & serr_en & sec_resp);

    // Reported data errors on the primary bus.
    assign pri_perr_event = (pri_cfg_err & pri_resp) |
                            (pri_read_err & pri_resp);

    // Reported data errors on the secondary bus.
    assign sec_perr_event = sec_read_err & sec_resp;

    // Config writes stay local and are never forwarded.
    assign pri_fwd_take = primary_data_valid & ~primary_cfg_write;

    // Write-one-to-clear mask, valid only for a status write.
    assign status_clear = reg_wdata[15:0];

    // ************************************************************
    // Claiming the transaction.
    // ************************************************************

    // An address error under response suppresses the primary claim.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            primary_devsel_n <= 1'b1;
        end else if (primary_addr_valid) begin
            primary_devsel_n <= ~(primary_hit &
                                  ~(pri_addr_err & pri_resp));
        end else if (primary_end) begin
            primary_devsel_n <= 1'b1;
        end
    end

    // The secondary claim follows the bridge control response bit.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            secondary_devsel_n <= 1'b1;
        end else if (secondary_addr_valid) begin
            secondary_devsel_n <= ~(secondary_hit &
                                    ~(sec_addr_err & sec_resp));
        end else if (secondary_end) begin
            secondary_devsel_n <= 1'b1;
        end
    end

    // ************************************************************
    // Config write acceptance and system error.
    // ************************************************************

    // A config write is always accepted and stored, good or bad.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            primary_target_ready_n <= 1'b1;
            cfg_data <= `CFG_DATA_RST;
        end else begin
            primary_target_ready_n <= ~(primary_data_valid &
                                        primary_cfg_write);
            if (primary_data_valid && primary_cfg_write) begin
                cfg_data <= primary_ad[31:0];
            end
        end
    end

    // The system error pin pulses one cycle after the address phase.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            primary_system_error_n <= 1'b1;
        end else begin
            primary_system_error_n <= ~serr_event;
        end
    end

    // ************************************************************
    // Parity error pins.
    // ************************************************************

    // An active low shift chain puts the pulse two cycles after the
    // data phase, so the pin itself is the last flip-flop.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pri_perr_pipe_n <= {`PERR_LAG{1'b1}};
            sec_perr_pipe_n <= {`PERR_LAG{1'b1}};
        end else begin
            pri_perr_pipe_n <= {pri_perr_pipe_n[`PERR_LAG-2:0],
                                ~pri_perr_event};
            sec_perr_pipe_n <= {sec_perr_pipe_n[`PERR_LAG-2:0],
                                ~sec_perr_event};
        end
    end

    assign primary_parity_error_n = pri_perr_pipe_n[`PERR_LAG-1];
    assign secondary_parity_error_n = sec_perr_pipe_n[`PERR_LAG-1];

    // ************************************************************
    // Forwarding across the bridge.
    // ************************************************************

    // Data and par cross unchanged; parity is never regenerated, so a
    // bad phase reaches the other side still bad. Prefetched data that
    // the initiator never takes is dropped by the buffers upstream.
    // A parity error raised by the initiator on returned read data
    // is left to that initiator and changes nothing here.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            secondary_fwd_valid <= 1'b0;
            secondary_fwd_ad <= {DATA_W{1'b0}};
            secondary_fwd_cbe <= {CMD_W{1'b0}};
            secondary_fwd_par <= 1'b0;
        end else begin
            secondary_fwd_valid <= pri_fwd_take;
            if (pri_fwd_take) begin
                secondary_fwd_ad <= primary_ad;
                secondary_fwd_cbe <= primary_cbe;
                secondary_fwd_par <= primary_par;
            end
        end
    end

    // Secondary data, including downstream read data, goes primary.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            primary_fwd_valid <= 1'b0;
            primary_fwd_ad <= {DATA_W{1'b0}};
            primary_fwd_cbe <= {CMD_W{1'b0}};
            primary_fwd_par <= 1'b0;
        end else begin
            primary_fwd_valid <= secondary_data_valid;
            if (secondary_data_valid) begin
                primary_fwd_ad <= secondary_ad;
                primary_fwd_cbe <= secondary_cbe;
                primary_fwd_par <= secondary_par;
            end
        end
    end

    // ************************************************************
    // Status flags.
    // ************************************************************

    // Set terms of the two status registers.
    always @* begin
        pri_status_set = 16'h0000;
        sec_status_set = 16'h0000;
        pri_status_set[`STAT_DET_PERR] = pri_addr_err |
                                         pri_cfg_err |
                                         pri_read_err;
        pri_status_set[`STAT_SIG_SERR] = serr_event;
        pri_status_set[`STAT_DATA_PERR] = pri_read_err &
                                          pri_resp;
        sec_status_set[`STAT_DET_PERR] = sec_addr_err |
                                         sec_read_err;
        sec_status_set[`STAT_DATA_PERR] = sec_read_err &
                                          sec_resp;
    end

    // Flags clear by writing one; a set in the same cycle wins.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pri_status <= `STATUS_RST;
            sec_status <= `STATUS_RST;
        end else begin
            if (reg_write && reg_addr == `REG_PRI_STATUS) begin
                pri_status <= (pri_status & ~status_clear) |
                              pri_status_set;
            end else begin
                pri_status <= pri_status | pri_status_set;
            end
            if (reg_write && reg_addr == `REG_SEC_STATUS) begin
                sec_status <= (sec_status & ~status_clear) |
                              sec_status_set;
            end else begin
                sec_status <= sec_status | sec_status_set;
            end
        end
    end

    // ************************************************************
    // Control registers.
    // ************************************************************

    // Only the implemented enable bits are kept; others read as zero.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pri_command <= `PRI_COMMAND_RST;
            bridge_ctrl <= `BRIDGE_CTRL_RST;
        end else if (reg_write) begin
            if (reg_addr == `REG_PRI_COMMAND) begin
                pri_command <= 16'h0000;
                pri_command[`CMD_PERR_RESP] <= reg_wdata[`CMD_PERR_RESP];
                pri_command[`CMD_SERR_EN] <= reg_wdata[`CMD_SERR_EN];
            end
            if (reg_addr == `REG_BRIDGE_CTRL) begin
                bridge_ctrl <= 16'h0000;
                bridge_ctrl[`BCTL_PERR_RESP] <= reg_wdata[`BCTL_PERR_RESP];
            end
        end
    end

    // ************************************************************
    // Register read port.
    // ************************************************************

    // Read mux; unmapped addresses answer zero.
    always @* begin
        case (reg_addr)
            `REG_PRI_COMMAND: next_rdata = {16'h0000, pri_command};
            `REG_PRI_STATUS: next_rdata = {16'h0000, pri_status};
            `REG_SEC_STATUS: next_rdata = {16'h0000, sec_status};
            `REG_BRIDGE_CTRL: next_rdata = {16'h0000, bridge_ctrl};
            `REG_CFG_DATA: next_rdata = cfg_data;
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Read data stand for one cycle only, zero at all other times,
    // which keeps stale values off the port between reads.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule // bridge_parity_error_handling

// ==== dv/pci_agent_model.sv ====
// Behavioural bus agent that presents one bus phase to the bridge.
`timescale 1ns/1ns

module pci_agent_model (
    // Clock and phase request from the bench.
    input wire clk_sys,
    input wire active,
    input wire [31:0] data,
    input wire [3:0] cmd,
    input wire corrupt,
    input wire check,
    // Bus lines toward the bridge.
    output wire [31:0] ad,
    output wire [3:0] cbe,
    output wire par,
    // Parity error report of the initiator role, active low.
    output wire perr_n
);
    reg [31:0] idle_pat = 32'h5A5AC3C3;
    reg [1:0] perr_pipe_n = 2'h3;

    // As initiator, a bad read phase is reported two cycles later.
    always @(posedge clk_sys) begin
        perr_pipe_n <= {perr_pipe_n[0],
                        ~(active & check & (^{ad, cbe, par}))};
    end

    assign perr_n = perr_pipe_n[1];

    // Released lines change every cycle, so a stale value never passes.
    always @(posedge clk_sys) begin
        idle_pat <= ~idle_pat;
    end

    // Even parity over the phase; corrupt flips it on purpose.
    assign ad = active ? data : idle_pat;
    assign cbe = active ? cmd : idle_pat[3:0];
    assign par = active ? (^{data, cmd}) ^ corrupt : idle_pat[4];
endmodule // pci_agent_model

// ==== dv/bridge_parity_monitor.sv ====
// Concurrent checks on the ports of the bridge parity block.
`timescale 1ns/1ns
`include "bridge_parity_consts.vh"

module bridge_parity_monitor #(
    parameter DATA_W = 32,
    parameter CMD_W = 4
) (
    // Clock, reset and register writes.
    input wire clk_sys,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_write,
    // Primary phases.
    input wire primary_addr_valid,
    input wire primary_data_valid,
    input wire [DATA_W-1:0] primary_ad,
    input wire [CMD_W-1:0] primary_cbe,
    input wire primary_par,
    input wire primary_hit,
    input wire primary_cfg_write,
    input wire primary_read_return,
    // Secondary phases.
    input wire secondary_addr_valid,
    input wire secondary_data_valid,
    input wire [DATA_W-1:0] secondary_ad,
    input wire [CMD_W-1:0] secondary_cbe,
    input wire secondary_par,
    input wire secondary_read_return,
    // Responses.
    input wire primary_devsel_n,
    input wire primary_parity_error_n,
    input wire primary_system_error_n,
    input wire secondary_devsel_n,
    input wire secondary_parity_error_n
);
    reg pri_resp;
    reg serr_en;
    reg sec_resp;

    // An odd count of ones over a phase marks bad parity.
    wire pri_bad = ^{primary_ad, primary_cbe, primary_par};
    wire sec_bad = ^{secondary_ad, secondary_cbe, secondary_par};
    wire serr_cause = serr_en && ((primary_addr_valid && pri_bad && pri_resp)
        || (secondary_addr_valid && sec_bad && sec_resp));

    // Shadow of the enable bits, so every check knows the gating state.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pri_resp <= 1'b0;
            serr_en <= 1'b0;
            sec_resp <= 1'b0;
        end else if (reg_write && reg_addr == `REG_PRI_COMMAND) begin
            pri_resp <= reg_wdata[`CMD_PERR_RESP];
            serr_en <= reg_wdata[`CMD_SERR_EN];
        end else if (reg_write && reg_addr == `REG_BRIDGE_CTRL) begin
            sec_resp <= reg_wdata[`BCTL_PERR_RESP];
        end
    end

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_pri_no_claim: assert property (
        primary_addr_valid && pri_bad && pri_resp |=> primary_devsel_n)
        else $error("primary claimed a bad address");
    a_pri_claim_good: assert property (
        primary_addr_valid && primary_hit && !(pri_bad && pri_resp)
        |=> !primary_devsel_n) else $error("primary claim missing");
    a_pri_serr_raise: assert property (
        primary_addr_valid && pri_bad && pri_resp && serr_en
        |=> !primary_system_error_n) else $error("system error missing");
    a_sec_no_claim: assert property (
        secondary_addr_valid && sec_bad && sec_resp |=> secondary_devsel_n)
        else $error("secondary claimed a bad address");
    a_serr_cause_only: assert property (
        !primary_system_error_n |-> $past(serr_cause))
        else $error("system error without enabled cause");
    a_cfg_perr_lag: assert property (
        primary_data_valid && primary_cfg_write && pri_bad && pri_resp
        |-> ##2 !primary_parity_error_n) else $error("config error late");
    a_up_read_perr: assert property (
        primary_data_valid && primary_read_return && pri_bad && pri_resp
        |=> ##1 !primary_parity_error_n) else $error("primary read error late");
    a_dn_read_perr: assert property (
        secondary_data_valid && secondary_read_return && sec_bad && sec_resp
        |-> ##2 !secondary_parity_error_n) else $error("secondary error late");

    c_pri_abort: cover property (primary_addr_valid && pri_bad && pri_resp);
    c_sec_abort: cover property (secondary_addr_valid && sec_bad && sec_resp);
    c_read_error: cover property (secondary_read_return && sec_bad);
endmodule // bridge_parity_monitor

// ==== dv/bridge_parity_error_handling_bench.sv ====
// Self-checking bench of the bridge parity and error handling block.
`timescale 1ns/1ns
`include "bridge_parity_consts.vh"

module bridge_parity_error_handling_bench;
    reg clk_sys = 1'b0;
    reg rst = 1'b1;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h00000000;
    reg reg_write = 1'b0;
    reg reg_read = 1'b0;
    reg cfg = 1'b0;
    reg [31:0] bus_data = 32'h00000000;
    reg [31:0] st_a, st_r;
    reg [1:0] av = 2'h0, dv = 2'h0, hit = 2'h0, rret = 2'h0;
    reg [1:0] fin = 2'h0, bad = 2'h0;
    integer err_total = 0, n_compared = 0, en, s;
    wire [31:0] reg_rdata, primary_ad, secondary_ad;
    wire [31:0] secondary_fwd_ad, primary_fwd_ad;
    wire [3:0] primary_cbe, secondary_cbe, secondary_fwd_cbe, primary_fwd_cbe;
    wire primary_par, secondary_par, primary_devsel_n, primary_target_ready_n;
    wire primary_parity_error_n, primary_system_error_n, secondary_devsel_n;
    wire secondary_parity_error_n, secondary_fwd_valid, secondary_fwd_par;
    wire primary_fwd_valid, primary_fwd_par;
    wire [1:0] ini_perr_n;
    // Per side, index 0 primary and 1 secondary; forwarded by initiator.
    wire [1:0] dev_n = {secondary_devsel_n, primary_devsel_n};
    wire [1:0] perr_n = {secondary_parity_error_n, primary_parity_error_n};
    wire [1:0] fwd_v = {primary_fwd_valid, secondary_fwd_valid};
    wire [1:0] fwd_p = {primary_fwd_par, secondary_fwd_par};

    // Bus agents on both sides present phases with even parity unless bad is set.
    pci_agent_model pri_u (.clk_sys(clk_sys), .active(av[0] | dv[0]),
        .data(bus_data), .cmd(bus_data[7:4]), .corrupt(bad[0]),
        .check(rret[0]), .perr_n(ini_perr_n[0]),
        .ad(primary_ad), .cbe(primary_cbe), .par(primary_par));
    pci_agent_model sec_u (.clk_sys(clk_sys), .active(av[1] | dv[1]),
        .data(bus_data), .cmd(bus_data[7:4]), .corrupt(bad[1]),
        .check(rret[1]), .perr_n(ini_perr_n[1]),
        .ad(secondary_ad), .cbe(secondary_cbe), .par(secondary_par));

    bridge_parity_error_handling dut_u (.clk_sys(clk_sys), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .primary_addr_valid(av[0]), .primary_data_valid(dv[0]),
        .primary_ad(primary_ad), .primary_cbe(primary_cbe),
        .primary_par(primary_par), .primary_hit(hit[0]),
        .primary_cfg_write(cfg), .primary_read_return(rret[0]),
        .primary_end(fin[0]), .secondary_addr_valid(av[1]),
        .secondary_data_valid(dv[1]), .secondary_ad(secondary_ad),
        .secondary_cbe(secondary_cbe), .secondary_par(secondary_par),
        .secondary_hit(hit[1]), .secondary_read_return(rret[1]),
        .secondary_end(fin[1]), .primary_devsel_n(primary_devsel_n),
        .primary_target_ready_n(primary_target_ready_n),
        .primary_parity_error_n(primary_parity_error_n),
        .primary_system_error_n(primary_system_error_n),
        .secondary_devsel_n(secondary_devsel_n),
        .secondary_parity_error_n(secondary_parity_error_n),
        .secondary_fwd_valid(secondary_fwd_valid),
        .secondary_fwd_ad(secondary_fwd_ad),
        .secondary_fwd_cbe(secondary_fwd_cbe),
        .secondary_fwd_par(secondary_fwd_par),
        .primary_fwd_valid(primary_fwd_valid), .primary_fwd_ad(primary_fwd_ad),
        .primary_fwd_cbe(primary_fwd_cbe), .primary_fwd_par(primary_fwd_par));

    always #5 clk_sys = ~clk_sys;

    // Compare one result; an unknown never counts as a match.
    task chk(input reg [31:0] got, input reg [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // One register access; a read compares the word of the next cycle.
    task reg_op(input reg w, input reg [7:0] a, input reg [31:0] d);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_wdata <= d;
            reg_write <= w;
            reg_read <= !w;
            @(posedge clk_sys);
            reg_write <= 1'b0;
            reg_read <= 1'b0;
            #1;
            if (!w) chk(reg_rdata, d);
        end
    endtask

    // One phase on side s, then the end pulse after an address phase and the two answer cycles.
    task phase(input integer s, input reg a, input reg c, input reg r,
        input reg [31:0] d, input reg b, input reg e_dev, input reg e_serr,
        input reg e_perr);
        reg [1:0] m;
        begin
            m = 2'h1 << s;
            @(posedge clk_sys);
            av <= a ? m : 2'h0;
            dv <= a ? 2'h0 : m;
            hit <= m;
            rret <= r ? m : 2'h0;
            bad <= b ? m : 2'h0;
            cfg <= c;
            bus_data <= d;
            @(posedge clk_sys);
            {av, dv, hit, rret, bad, cfg} <= 11'h000;
            fin <= a ? m : 2'h0;
            #1;
            chk(dev_n[s], e_dev);
            chk(primary_system_error_n, e_serr);
            if (!a) begin
                chk(primary_target_ready_n, !c);
                chk(fwd_v[s], !c);
                if (!c) begin
                    chk(s ? primary_fwd_ad : secondary_fwd_ad, d);
                    chk(s ? primary_fwd_cbe : secondary_fwd_cbe,
                        d[7:4]);
                    chk(fwd_p[s], ^{d, d[7:4]} ^ b);
                end
            end
            @(posedge clk_sys);
            fin <= 2'h0;
            #1;
            chk(perr_n[s], e_perr);
            chk(ini_perr_n[s], !(r & b));
            chk(dev_n[s], 1'b1);
        end
    endtask

    task summarize;
        begin
            $display("compared %0d mismatches %0d", n_compared, err_total);
            if (err_total == 0 && n_compared > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    // Reset values, then each check with parity response on and off.
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        for (s = 0; s <= 16; s = s + 4) reg_op(0, s[7:0], 32'h00000000);
        reg_op(0, 8'h20, 32'h00000000);
        for (en = 1; en >= 0; en = en - 1) begin
            st_a = en ? 32'h0000C000 : 32'h00008000;
            st_r = en ? 32'h00008100 : 32'h00008000;
            reg_op(1, `REG_PRI_COMMAND, en ? 32'h00000140 : 32'h00000100);
            reg_op(1, `REG_BRIDGE_CTRL, en);
            reg_op(0, `REG_BRIDGE_CTRL, en);
            phase(0, 1, 0, 0, 32'h12345678, 0, 0, 1, 1);
            phase(0, 1, 0, 0, 32'hA5A50F0F, 1, en, !en, 1);
            reg_op(0, `REG_PRI_STATUS, st_a);
            phase(1, 1, 0, 0, 32'h0F0FA5A5, 1, en, !en, 1);
            reg_op(0, `REG_SEC_STATUS, 32'h00008000);
            reg_op(0, `REG_PRI_STATUS, st_a);
            reg_op(1, `REG_PRI_STATUS, 32'h0000C100);
            phase(0, 0, 1, 0, 32'hCAFE0000, 1, 1, 1, !en);
            reg_op(0, `REG_CFG_DATA, 32'hCAFE0000);
            reg_op(0, `REG_PRI_STATUS, 32'h00008000);
            reg_op(1, `REG_PRI_STATUS, 32'h0000C100);
            reg_op(1, `REG_SEC_STATUS, 32'h0000C100);
            for (s = 0; s < 2; s = s + 1) begin
                phase(s, 0, 0, 1, 32'h600DF00D, 0, 1, 1, 1);
                phase(s, 0, 0, 1, 32'hBAD0BEEF, 1, 1, 1, !en);
            end
            reg_op(0, `REG_PRI_STATUS, st_r);
            reg_op(0, `REG_SEC_STATUS, st_r);
            reg_op(1, `REG_PRI_STATUS, 32'h0000C100);
            reg_op(1, `REG_SEC_STATUS, 32'h0000C100);
        end
        summarize;
    end
endmodule // bridge_parity_error_handling_bench

bind bridge_parity_error_handling bridge_parity_monitor #(.DATA_W(DATA_W),
    .CMD_W(CMD_W)) mon_u (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .primary_addr_valid(primary_addr_valid),
    .primary_data_valid(primary_data_valid), .primary_ad(primary_ad),
    .primary_cbe(primary_cbe), .primary_par(primary_par),
    .primary_hit(primary_hit), .primary_cfg_write(primary_cfg_write),
    .primary_read_return(primary_read_return),
    .secondary_addr_valid(secondary_addr_valid),
    .secondary_data_valid(secondary_data_valid),
    .secondary_ad(secondary_ad), .secondary_cbe(secondary_cbe),
    .secondary_par(secondary_par),
    .secondary_read_return(secondary_read_return),
    .primary_devsel_n(primary_devsel_n),
    .primary_parity_error_n(primary_parity_error_n),
    .primary_system_error_n(primary_system_error_n),
    .secondary_devsel_n(secondary_devsel_n),
    .secondary_parity_error_n(secondary_parity_error_n));
